// ---- verilog/synth_ctrl_regs.svh ----
`ifndef SYNTH_CTRL_REGS_SVH
`define SYNTH_CTRL_REGS_SVH
// register addresses
`define ADDR_REFERENCE_INPUT_CONFIG 8'h22
`define ADDR_RESYNC_AND_TRACKING_CONFIG 8'h23
`define ADDR_FEEDBACK_AND_OUTPUT_DIVIDER 8'h24
`define ADDR_RF_OUTPUT_CONTROL 8'h25
`define ADDR_BLEED_CURRENT_SETTING 8'h26
// reset values
`define RST_REFERENCE_INPUT_CONFIG 8'h00
`define RST_RESYNC_AND_TRACKING_CONFIG 8'h00
`define RST_FEEDBACK_AND_OUTPUT_DIVIDER 8'h80
`define RST_RF_OUTPUT_CONTROL 8'h07
`define RST_BLEED_CURRENT_SETTING 8'h32
// writable bit masks, reserved bits are zero
`define MASK_REFERENCE_INPUT_CONFIG 8'h70
`define MASK_RESYNC_AND_TRACKING_CONFIG 8'h32
`define MASK_FEEDBACK_AND_OUTPUT_DIVIDER 8'hF0
`define MASK_RF_OUTPUT_CONTROL 8'hBF
`define MASK_BLEED_CURRENT_SETTING 8'hFF
// field positions
`define BIT_REF_DIFF 6
`define BIT_REF_DOUBLER 5
`define BIT_REF_HALF 4
`define BIT_RESYNC_HI 5
`define BIT_RESYNC_LO 4
`define BIT_TRACK_MANUAL 1
`define BIT_FEEDBACK_SEL 7
`define BIT_DIV_HI 6
`define BIT_DIV_LO 4
`define BIT_MUTE_LOCK 7
`define BIT_DIV_BUFFERED 5
`define BIT_QUAD_EN 4
`define BIT_DOUBLER_EN 3
`define BIT_RF_OUTPUT_ENABLE 2
`define BIT_POWER_HI 1
`define BIT_POWER_LO 0
// codes
`define RESYNC_ON_CODE 2'b10
`define DIV_RESERVED_CODE 3'h7
// lock window counts, in phase detector cycles
`define LOCK_COUNT_SHORT 12'h3FF
`define LOCK_COUNT_LONG 12'h7FF
`endif

// ---- verilog/synth_ctrl_pkg.sv ----
package synth_ctrl_pkg;
  // decoded control settings toward the analog side
  typedef struct packed {
    logic reference_input_differential;
    logic reference_doubler_enable;
    logic reference_half_divider_enable;
    logic resync_enable;
    logic tracking_manual;
    logic feedback_source_select;
    logic [2:0] division_ratio_code;
    logic quadrupler_path_enable;
    logic doubler_path_enable;
    logic rf_output_active;
    logic [1:0] output_power_level;
    logic [7:0] bleed_current_code;
  } ctrl_out_type;
  // register write request from the serial interface
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_type;
  typedef enum logic [0:0] {LOCK_HUNT, LOCK_HELD} lock_state_type;
endpackage

// ---- verilog/lock_detect_counter.sv ----
`timescale 1ns/1ps
`include "synth_ctrl_regs.svh"
// counts consecutive in-window phase detector cycles; declares lock on the programmed count
module lock_detect_counter (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic pfd_tick_in, // one pulse per phase detector cycle
  input wire logic in_window_in, // phase error inside lock window on this tick
  input wire logic long_count_in, // 1 selects 2048 cycles, 0 selects 1024
  output logic locked_out
);
  logic [11:0] count_q, count_d; // in-window ticks seen so far
  synth_ctrl_pkg::lock_state_type state_q, state_d;
  logic [11:0] target; // last count before lock

  // next-state logic
  always_comb begin
    target = long_count_in ? `LOCK_COUNT_LONG : `LOCK_COUNT_SHORT;
    count_d = count_q;
    state_d = state_q;
    if (pfd_tick_in) begin
      if (!in_window_in) begin
        // any slip restarts the count and drops lock
        count_d = 12'h0000;
        state_d = synth_ctrl_pkg::LOCK_HUNT;
      end else begin
        case (state_q)
          synth_ctrl_pkg::LOCK_HUNT: begin
            if (count_q >= target) begin
              state_d = synth_ctrl_pkg::LOCK_HELD; // [R15]
            end else begin
              count_d = count_q + 12'h0001;
            end
          end
          synth_ctrl_pkg::LOCK_HELD: begin
            count_d = count_q;
          end
          default: begin
            state_d = synth_ctrl_pkg::LOCK_HUNT;
          end
        endcase
      end
    end
  end

  // registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_q <= 12'h0000;
      state_q <= synth_ctrl_pkg::LOCK_HUNT;
    end else begin
      count_q <= count_d;
      state_q <= state_d;
    end
  end

  assign locked_out = (state_q == synth_ctrl_pkg::LOCK_HELD);
endmodule

// ---- verilog/synth_ref_output_ctrl_regs.sv ----
`timescale 1ns/1ps
`include "synth_ctrl_regs.svh"
// How it works
// [R1] registers reset to 00,00,80,07,32
// [R2] bit6 selects differential reference input
// [R3] bit5 enables reference doubler
// [R4] bit4 enables reference divide-by-two stage
// [R5] resync mode field, code 10 enables
// [R6] bit1 selects manual tracking filter coefficients
// [R7] bit7 feedback: 1 fundamental, 0 divided
// [R8] division field codes 0-6, 7 reserved
// [R9] mute output until digital lock asserted
// [R10] buffered division applies on update event
// [R11] bit4 quadrupler, bit3 doubler path enables
// [R12] bit2 enables RF output, default on
// [R13] power code 0-3 gives -4..5 dBm
// [R14] eight-bit bleed current, default 0x32
// [R15] lock after 1024 or 2048 window cycles
// [R16] reserved bits read zero, writes ignored
// [R17] host writes whole bytes, keeps reserved defaults
module synth_ref_output_ctrl_regs (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire synth_ctrl_pkg::reg_write_type wr_in, // whole-byte write from serial logic
  input wire logic [7:0] rd_addr_in, // readback address
  input wire logic buffer_update_in, // double buffer update event pulse
  input wire logic pfd_tick_in, // phase detector cycle pulse
  input wire logic in_window_in, // phase error inside lock window
  input wire logic lock_window_cycle_count_in, // 0: 1024, 1: 2048 cycles
  output logic [7:0] rd_data_out,
  output logic lock_detect_out,
  output logic division_code_reserved_out, // reserved ratio code is held
  output synth_ctrl_pkg::ctrl_out_type ctrl_out
);
  // register storage
  logic [7:0] ref_cfg_q, ref_cfg_d;
  logic [7:0] resync_cfg_q, resync_cfg_d;
  logic [7:0] fb_div_q, fb_div_d;
  logic [7:0] rf_ctl_q, rf_ctl_d;
  logic [7:0] bleed_q, bleed_d;
  // division ratio actually applied to the output divider
  logic [2:0] div_active_q, div_active_d;
  logic div_pending_q, div_pending_d; // buffered value waiting for update
  logic [7:0] rd_data_d;
  logic locked; // from lock counter, already a flop
  synth_ctrl_pkg::ctrl_out_type ctrl_q, ctrl_d;
  logic [2:0] div_written;

  // lock detect counter, gating the mute function
  lock_detect_counter lock_counter (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .pfd_tick_in(pfd_tick_in),
    .in_window_in(in_window_in),
    .long_count_in(lock_window_cycle_count_in),
    .locked_out(locked)
  );

  // register writes; reserved bits are masked off so they stay zero
  always_comb begin
    ref_cfg_d = ref_cfg_q;
    resync_cfg_d = resync_cfg_q;
    fb_div_d = fb_div_q;
    rf_ctl_d = rf_ctl_q;
    bleed_d = bleed_q;
    if (wr_in.en) begin
      // a write is one whole byte; no partial field updates exist
      case (wr_in.addr)
        `ADDR_REFERENCE_INPUT_CONFIG: begin
          ref_cfg_d = wr_in.data & `MASK_REFERENCE_INPUT_CONFIG; // [R16]
        end
        `ADDR_RESYNC_AND_TRACKING_CONFIG: begin
          resync_cfg_d = wr_in.data & `MASK_RESYNC_AND_TRACKING_CONFIG; // [R16]
        end
        `ADDR_FEEDBACK_AND_OUTPUT_DIVIDER: begin
          fb_div_d = wr_in.data & `MASK_FEEDBACK_AND_OUTPUT_DIVIDER; // [R16]
        end
        `ADDR_RF_OUTPUT_CONTROL: begin
          rf_ctl_d = wr_in.data & `MASK_RF_OUTPUT_CONTROL; // [R16]
        end
        `ADDR_BLEED_CURRENT_SETTING: begin
          bleed_d = wr_in.data; // [R14]
        end
        default: begin
          // other addresses belong to other blocks
          bleed_d = bleed_q;
        end
      endcase
    end
  end

  // division ratio path: immediate, or held until the update event
  always_comb begin
    div_written = fb_div_d[`BIT_DIV_HI:`BIT_DIV_LO];
    div_active_d = div_active_q;
    div_pending_d = div_pending_q;
    if (wr_in.en && wr_in.addr == `ADDR_FEEDBACK_AND_OUTPUT_DIVIDER) begin
      if (rf_ctl_q[`BIT_DIV_BUFFERED]) begin
        div_pending_d = 1'b1; // [R10]
      end else begin
        div_active_d = div_written; // [R8]
        div_pending_d = 1'b0;
      end
    end
    // an update in the write cycle picks up the new value, so nothing is lost
    if (buffer_update_in && div_pending_d) begin
      div_active_d = div_written; // [R10]
      div_pending_d = 1'b0;
    end
    // turning buffering off releases any held value at once
    if (!rf_ctl_d[`BIT_DIV_BUFFERED] && div_pending_d) begin
      div_active_d = div_written;
      div_pending_d = 1'b0;
    end
  end

  // decode the control outputs
  always_comb begin
    ctrl_d.reference_input_differential = ref_cfg_q[`BIT_REF_DIFF]; // [R2]
    ctrl_d.reference_doubler_enable = ref_cfg_q[`BIT_REF_DOUBLER]; // [R3]
    ctrl_d.reference_half_divider_enable = ref_cfg_q[`BIT_REF_HALF]; // [R4]
    // only the documented code turns resync on; 01 and 11 act as off
    ctrl_d.resync_enable = (resync_cfg_q[`BIT_RESYNC_HI:`BIT_RESYNC_LO] == `RESYNC_ON_CODE); // [R5]
    ctrl_d.tracking_manual = resync_cfg_q[`BIT_TRACK_MANUAL]; // [R6]
    ctrl_d.feedback_source_select = fb_div_q[`BIT_FEEDBACK_SEL]; // [R7]
    ctrl_d.division_ratio_code = div_active_q; // [R8]
    ctrl_d.quadrupler_path_enable = rf_ctl_q[`BIT_QUAD_EN]; // [R11]
    ctrl_d.doubler_path_enable = rf_ctl_q[`BIT_DOUBLER_EN]; // [R11]
    // output stays muted while mute-to-lock is set and lock is absent
    ctrl_d.rf_output_active = rf_ctl_q[`BIT_RF_OUTPUT_ENABLE] &
      (~rf_ctl_q[`BIT_MUTE_LOCK] | locked); // [R9] [R12]
    ctrl_d.output_power_level = rf_ctl_q[`BIT_POWER_HI:`BIT_POWER_LO]; // [R13]
    ctrl_d.bleed_current_code = bleed_q; // [R14]
  end

  // readback mux; unknown addresses read zero
  always_comb begin
    case (rd_addr_in)
      `ADDR_REFERENCE_INPUT_CONFIG: begin
        rd_data_d = ref_cfg_q;
      end
      `ADDR_RESYNC_AND_TRACKING_CONFIG: begin
        rd_data_d = resync_cfg_q;
      end
      `ADDR_FEEDBACK_AND_OUTPUT_DIVIDER: begin
        rd_data_d = fb_div_q;
      end
      `ADDR_RF_OUTPUT_CONTROL: begin
        rd_data_d = rf_ctl_q;
      end
      `ADDR_BLEED_CURRENT_SETTING: begin
        rd_data_d = bleed_q;
      end
      default: begin
        rd_data_d = 8'h00;
      end
    endcase
  end

  // state registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ref_cfg_q <= `RST_REFERENCE_INPUT_CONFIG; // [R1]
      resync_cfg_q <= `RST_RESYNC_AND_TRACKING_CONFIG; // [R1]
      fb_div_q <= `RST_FEEDBACK_AND_OUTPUT_DIVIDER; // [R1]
      rf_ctl_q <= `RST_RF_OUTPUT_CONTROL; // [R1]
      bleed_q <= `RST_BLEED_CURRENT_SETTING; // [R1]
      div_active_q <= 3'h0;
      div_pending_q <= 1'b0;
    end else begin
      ref_cfg_q <= ref_cfg_d;
      resync_cfg_q <= resync_cfg_d;
      fb_div_q <= fb_div_d;
      rf_ctl_q <= rf_ctl_d;
      bleed_q <= bleed_d;
      div_active_q <= div_active_d;
      div_pending_q <= div_pending_d;
    end
  end

  // output registers; reset loads all zeros, not the decoded reset register contents
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_data_out <= 8'h00;
      lock_detect_out <= 1'b0;
      division_code_reserved_out <= 1'b0;
      ctrl_q <= '0;
    end else begin
      rd_data_out <= rd_data_d;
      lock_detect_out <= locked;
      division_code_reserved_out <= (div_active_q == `DIV_RESERVED_CODE); // [R8]
      ctrl_q <= ctrl_d;
    end
  end

  assign ctrl_out = ctrl_q;
endmodule

// ---- verification/synth_ref_output_ctrl_regs_chk.sv ----
`timescale 1ns/1ps
// watches the bank ports; a write settles on ctrl_out one edge after it is taken
module synth_ref_output_ctrl_regs_chk (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire synth_ctrl_pkg::reg_write_type wr_in,
  input wire logic [7:0] rd_addr_in,
  input wire logic buffer_update_in,
  input wire logic pfd_tick_in,
  input wire logic in_window_in,
  input wire logic lock_window_cycle_count_in,
  input wire logic [7:0] rd_data_out,
  input wire logic lock_detect_out,
  input wire logic division_code_reserved_out,
  input wire synth_ctrl_pkg::ctrl_out_type ctrl_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  logic [7:0] d1_q; // write byte one edge back
  logic [7:0] d2_q; // write byte two edges back, lines up with a settled write
  always_ff @(posedge clk_in) begin
    d1_q <= wr_in.data;
    d2_q <= d1_q;
  end
  // a write not overwritten at the same place on the next edge
  sequence s_wr(logic [7:0] a);
    wr_in.en && wr_in.addr == a ##1 !(wr_in.en && wr_in.addr == a);
  endsequence
  property p_ref;
    s_wr(8'h22) |=> {ctrl_out.reference_input_differential, ctrl_out.reference_doubler_enable,
      ctrl_out.reference_half_divider_enable} == d2_q[6:4];
  endproperty
  a_ref: assert property (p_ref) else $error("reference settings wrong");
  property p_sync;
    s_wr(8'h23) |=> ctrl_out.resync_enable == (d2_q[5:4] == 2'b10) && ctrl_out.tracking_manual == d2_q[1];
  endproperty
  a_sync: assert property (p_sync) else $error("resync or tracking wrong");
  property p_fb;
    s_wr(8'h24) |=> ctrl_out.feedback_source_select == d2_q[7];
  endproperty
  a_fb: assert property (p_fb) else $error("feedback select wrong");
  property p_out;
    s_wr(8'h25) |=> {ctrl_out.quadrupler_path_enable, ctrl_out.doubler_path_enable,
      ctrl_out.output_power_level} == {d2_q[4:3], d2_q[1:0]};
  endproperty
  a_out: assert property (p_out) else $error("output path settings wrong");
  property p_bleed;
    s_wr(8'h26) |=> ctrl_out.bleed_current_code == d2_q;
  endproperty
  a_bleed: assert property (p_bleed) else $error("bleed code wrong");
  property p_unm;
    !(rd_addr_in inside {[8'h22:8'h26]}) |=> rd_data_out == 8'h00;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_rsv;
    rd_addr_in == 8'h22 |=> (rd_data_out & 8'h8F) == 8'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits read set");
  property p_lclr;
    pfd_tick_in && !in_window_in |-> ##2 !lock_detect_out;
  endproperty
  a_lclr: assert property (p_lclr) else $error("lock kept after miss");
  property p_lrise;
    $rose(lock_detect_out) |-> $past(pfd_tick_in, 2) && $past(in_window_in, 2);
  endproperty
  a_lrise: assert property (p_lrise) else $error("lock rose without tick");
  c_lock: cover property ($rose(lock_detect_out) && lock_window_cycle_count_in);
  c_upd: cover property (buffer_update_in ##2 ctrl_out.division_ratio_code == 3'h3);
  c_rsv: cover property (division_code_reserved_out);
endmodule

// ---- verification/host_ctrl_model.sv ----
`timescale 1ns/1ps
// host side of the serial path: one whole byte handed over per taking edge
module host_ctrl_model (
  input wire logic clk_in,
  output synth_ctrl_pkg::reg_write_type wr_out
);
  initial wr_out = '0;
  // present just after an edge, hold through the taking edge
  task write(input logic [7:0] ad, input logic [7:0] dt);
    wr_out = '{en: 1'b1, addr: ad, data: dt};
    @(posedge clk_in);
    #1;
  endtask
  // released lines flip, so a stale byte is never mistaken for a live one
  task idle;
    wr_out = '{en: 1'b0, addr: ~wr_out.addr, data: ~wr_out.data};
  endtask
endmodule

// ---- verification/synth_ref_output_ctrl_regs_bench.sv ----
`timescale 1ns/1ps
module synth_ref_output_ctrl_regs_bench;
  logic clk_in, rst_b_in, buffer_update_in, pfd_tick_in, in_window_in, lock_window_cycle_count_in;
  logic [7:0] rd_addr_in, rd_data_out, a, d;
  logic lock_detect_out, division_code_reserved_out;
  synth_ctrl_pkg::reg_write_type wr_in;
  synth_ctrl_pkg::ctrl_out_type ctrl_out;
  logic [7:0] m [5]; // model bytes, 0x22 upward
  logic [7:0] rv [5] = '{8'h00, 8'h00, 8'h80, 8'h07, 8'h32}; // reset bytes
  logic [7:0] mk [5] = '{8'h70, 8'h32, 8'hF0, 8'hBF, 8'hFF}; // writable bits
  logic [2:0] code; // applied ratio code
  logic lk; // model lock
  int n_fail, n_tests, i, k, seed;
  host_ctrl_model host (.clk_in(clk_in), .wr_out(wr_in));
  synth_ref_output_ctrl_regs DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .wr_in(wr_in), .rd_addr_in(rd_addr_in),
    .buffer_update_in(buffer_update_in), .pfd_tick_in(pfd_tick_in), .in_window_in(in_window_in),
    .lock_window_cycle_count_in(lock_window_cycle_count_in), .rd_data_out(rd_data_out),
    .lock_detect_out(lock_detect_out), .division_code_reserved_out(division_code_reserved_out), .ctrl_out(ctrl_out));
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // expected decode; output stays muted until lock when mute is set
  function automatic synth_ctrl_pkg::ctrl_out_type ex();
    return {m[0][6:4], m[1][5:4] == 2'b10, m[1][1], m[2][7], code, m[3][4:3], m[3][2] & (~m[3][7] | lk),
      m[3][1:0], m[4]};
  endfunction
  // readback lags the address by one edge
  task look(input logic [7:0] ad);
    rd_addr_in = ad;
    @(posedge clk_in);
    #1;
    chk(rd_data_out, (ad >= 8'h22 && ad <= 8'h26) ? m[ad - 8'h22] : 8'h00);
    chk(ctrl_out, ex());
    chk(lock_detect_out, lk);
    chk(division_code_reserved_out, code == 3'h7);
  endtask
  task wr(input logic [7:0] ad, input logic [7:0] dt);
    host.write(ad, dt);
    if (ad >= 8'h22 && ad <= 8'h26) m[ad - 8'h22] = dt & mk[ad - 8'h22];
    if (!m[3][5]) code = m[2][6:4];
  endtask
  task tick(input logic w);
    in_window_in = w;
    pfd_tick_in = 1'b1;
    @(posedge clk_in);
    #1;
    pfd_tick_in = 1'b0;
    @(posedge clk_in);
    #1;
  endtask
  task test_done;
    if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk_in);
    n_fail++;
    test_done();
  end
  initial begin
    seed = 32'hc639_0b63;
    rst_b_in = 1'b0;
    rd_addr_in = 8'h22;
    buffer_update_in = 1'b0;
    pfd_tick_in = 1'b0;
    in_window_in = 1'b0;
    lock_window_cycle_count_in = 1'b0;
    m = rv;
    code = 3'h0;
    lk = 1'b0;
    repeat (4) @(posedge clk_in);
    #1 rst_b_in = 1'b1;
    for (a = 8'h21; a != 8'h28; a++) look(a);
    // random pairs of back-to-back writes, unmapped places included
    for (i = 0; i < 40; i++) begin
      a = 8'h21 + 8'({$random(seed)} % 7);
      d = $random(seed);
      if (a == 8'h23) d[4] = 1'b0;
      if (a == 8'h25) d[5] = 1'b0;
      wr(a, d);
      if (i[0]) begin
        host.idle();
        look(a);
      end
    end
    // buffered ratio waits for the update pulse; clearing the buffer bit releases it
    wr(8'h25, 8'h27);
    wr(8'h24, 8'hB0);
    host.idle();
    look(8'h24);
    buffer_update_in = 1'b1;
    @(posedge clk_in);
    #1;
    buffer_update_in = 1'b0;
    code = m[2][6:4];
    look(8'h24);
    wr(8'h24, 8'hF0);
    wr(8'h25, 8'h07);
    host.idle();
    look(8'h25);
    // muted output stays shut one tick short of the window count and opens on the last one
    for (k = 0; k < 2; k++) begin
      lock_window_cycle_count_in = k[0];
      wr(8'h25, 8'h87);
      host.idle();
      repeat ((1024 << k) - 1) tick(1'b1);
      look(8'h25);
      tick(1'b1);
      lk = 1'b1;
      look(8'h25);
      tick(1'b0);
      lk = 1'b0;
      look(8'h25);
    end
    // second reset in mid-run restores the defaults
    rst_b_in = 1'b0;
    @(posedge clk_in);
    #1 rst_b_in = 1'b1;
    m = rv;
    code = 3'h0;
    look(8'h25);
    test_done();
  end
endmodule
bind synth_ref_output_ctrl_regs synth_ref_output_ctrl_regs_chk chk_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
  .wr_in(wr_in), .rd_addr_in(rd_addr_in), .buffer_update_in(buffer_update_in), .pfd_tick_in(pfd_tick_in),
  .in_window_in(in_window_in), .lock_window_cycle_count_in(lock_window_cycle_count_in), .rd_data_out(rd_data_out),
  .lock_detect_out(lock_detect_out), .division_code_reserved_out(division_code_reserved_out), .ctrl_out(ctrl_out));
